/* hw/lead_reserve_arbiter.sv */
// Purpose: lead/reserve arbitration, failover, mode and scan sequencing
// Assumes: pins from rack, switch module and peer are asynchronous
// Notes: one instance per cpu; left_position strap tells the rack slot
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module lead_reserve_arbiter #(
  parameter int analog_cycles = lead_reserve_pkg::analog_scan_cycles,
  parameter int logic_cycles = lead_reserve_pkg::logic_scan_cycles,
  parameter int block_count = 128
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic self_available,
  input wire logic peer_available,
  input wire logic peer_is_lead,
  input wire logic left_position,
  input wire logic self_fault,
  input wire logic peer_fault,
  input wire logic rack_comm_lost,
  input wire logic proc_exception,
  input wire logic host_comm_lost,
  input wire logic slave_comm_lost,
  input wire logic oi_comm_lost,
  input wire logic peer_ctrl_comm_lost,
  input wire logic key_failover,
  input wire logic redundancy_status_block_failover,
  input wire logic [1:0] key_mode,
  input wire logic [1:0] peer_mode,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic is_lead,
  output logic is_reserve,
  output logic failover_pulse,
  output logic [1:0] mode,
  output logic status_to_peer,
  output logic poll_racks,
  output logic sample_inputs,
  output logic exec_block,
  output logic [7:0] block_num,
  output logic user_block,
  output logic write_outputs,
  output logic outputs_off,
  output logic net_tx_enable,
  output logic sync_runtime,
  output logic sync_config,
  output logic cold_start,
  output logic store_flash,
  output logic reserve_diag
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int npins = 18;
  logic [npins-1:0] pins_raw;
  logic [npins-1:0] pins;
  assign pins_raw = {peer_mode, key_mode, redundancy_status_block_failover, key_failover,
                     peer_ctrl_comm_lost, oi_comm_lost, slave_comm_lost, host_comm_lost,
                     proc_exception, rack_comm_lost, peer_fault, self_fault, left_position,
                     peer_is_lead, peer_available, self_available};
  input_sync #(.width(npins)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d(pins_raw),
    .q(pins)
  );
  logic s_avail, p_avail, p_lead, s_left, s_fault, p_fault, s_rack, s_exc;
  logic s_keyfo, s_rsfo;
  logic [1:0] s_keymode, s_peermode;
  assign s_avail = pins[0];
  assign p_avail = pins[1];
  assign p_lead = pins[2];
  assign s_left = pins[3];
  assign s_fault = pins[4];
  assign p_fault = pins[5];
  assign s_rack = pins[6];
  assign s_exc = pins[7];
  assign s_keyfo = pins[12];
  assign s_rsfo = pins[13];
  assign s_keymode = pins[15:14];
  assign s_peermode = pins[17:16];
  // pins[11:8] are the non-failover link losses; they deliberately feed nothing

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic decided;
    logic lead;
    logic fo;
    logic [1:0] mode;
    logic cold;
    logic flash;
    logic [31:0] host_word;
    logic [7:0] ctrl;
    logic [2:0] diag;
    lead_reserve_pkg::scan_state_t st;
    logic [31:0] scan_cnt;
    logic [31:0] logic_cnt;
    logic [7:0] blk;
    logic [1:0] fo_cnt;
    logic peer_was_avail;
    logic cfg_sync;
    logic rt_sync;
    logic awr;
    logic wr;
    logic bv;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic keyfo_d;
    logic rsfo_d;
    logic [1:0] key_d;
    logic arr;
  } state_t;
  state_t s_r, s_nxt;

  logic manual_fo, auto_fo, wr_go, edit_ok;
  logic [7:0] waddr, raddr;
  assign waddr = s_axi_awaddr[7:0];
  assign raddr = s_axi_araddr[7:0];
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_r.bv;

  always_comb begin
    s_nxt = s_r;
    s_nxt.fo = 1'b0;
    s_nxt.cold = 1'b0;
    s_nxt.flash = 1'b0;
    s_nxt.cfg_sync = 1'b0;
    s_nxt.rt_sync = 1'b0;
    s_nxt.keyfo_d = s_keyfo;
    s_nxt.rsfo_d = s_rsfo;
    s_nxt.key_d = s_keymode;
    edit_ok = 1'b0;
    // -------------------------------------------------------------
    // start-up arbitration
    // -------------------------------------------------------------
    if (!s_r.decided && s_avail) begin
      s_nxt.decided = 1'b1;
      if (p_lead) begin
        s_nxt.lead = 1'b0;
      end else if (p_avail) begin
        s_nxt.lead = s_left;
      end else begin
        s_nxt.lead = 1'b1;
      end
    end
    // -------------------------------------------------------------
    // failover: lead faults hand over, reserve faults only flag
    // -------------------------------------------------------------
    manual_fo = (s_keyfo && !s_r.keyfo_d) || (s_rsfo && !s_r.rsfo_d)
                || (wr_go && waddr == lead_reserve_pkg::reg_ctrl
                    && (s_axi_wdata[lead_reserve_pkg::ctrl_fo_pc]
                        || s_axi_wdata[lead_reserve_pkg::ctrl_fo_host]));
    auto_fo = s_fault || s_rack || s_exc;
    if (s_r.decided && s_r.lead && (auto_fo || manual_fo) && p_avail && !p_fault) begin
      // handover completes in this cycle, far inside the 4-cycle budget
      s_nxt.lead = 1'b0;
      s_nxt.fo = 1'b1;
      s_nxt.diag[lead_reserve_pkg::diag_failover_seen] = 1'b1;
    end else if (s_r.decided && !s_r.lead && !p_lead && (p_fault || !p_avail)) begin
      s_nxt.lead = 1'b1;
      s_nxt.fo = 1'b1;
      s_nxt.diag[lead_reserve_pkg::diag_failover_seen] = 1'b1;
    end
    if (s_r.lead && (p_fault || !p_avail)) begin
      s_nxt.diag[lead_reserve_pkg::diag_reserve_fault] = 1'b1;
    end
    // -------------------------------------------------------------
    // mode: key, pc register, host word bit 6; reserve follows lead
    // -------------------------------------------------------------
    // key acts on changes only; a steady key must not undo pc or host writes
    if (s_r.decided && !s_r.lead && p_avail) begin
      s_nxt.mode = s_peermode;
    end else if (s_r.lead && s_keymode != s_r.key_d && s_keymode != 2'h3) begin
      s_nxt.mode = s_keymode;
    end
    if (wr_go && s_r.lead) begin
      case (waddr)
        lead_reserve_pkg::reg_ctrl: begin
          s_nxt.ctrl = s_axi_wdata[7:0];
          if (s_axi_wdata[lead_reserve_pkg::ctrl_mode_wr]
              && s_axi_wdata[1:0] != 2'h3) begin
            s_nxt.mode = s_axi_wdata[1:0];
          end
          if (s_axi_wdata[lead_reserve_pkg::ctrl_edit]) begin
            edit_ok = s_r.mode != lead_reserve_pkg::mode_run;
            s_nxt.diag[lead_reserve_pkg::diag_edit_rejected] = !edit_ok;
            s_nxt.flash = edit_ok;
            s_nxt.cfg_sync = edit_ok;
          end
          if (s_axi_wdata[lead_reserve_pkg::ctrl_download]) begin
            s_nxt.cfg_sync = 1'b1;
          end
        end
        lead_reserve_pkg::reg_host_word: begin
          s_nxt.host_word = s_axi_wdata;
          s_nxt.mode = s_axi_wdata[lead_reserve_pkg::host_prog_bit]
                       ? lead_reserve_pkg::mode_prog
                       : lead_reserve_pkg::mode_run;
        end
        lead_reserve_pkg::reg_diag: begin
          // write one to clear; a fresh event this cycle wins
          s_nxt.diag = s_r.diag & ~s_axi_wdata[2:0] | (s_nxt.diag & ~s_r.diag);
        end
        default: begin
        end
      endcase
    end
    if (s_r.mode == lead_reserve_pkg::mode_prog && s_nxt.mode != lead_reserve_pkg::mode_prog) begin
      s_nxt.cold = 1'b1;
      s_nxt.flash = 1'b1;
    end
    // reserve coming on-line gets the configuration database
    s_nxt.peer_was_avail = p_avail;
    if (s_r.lead && p_avail && !s_r.peer_was_avail) begin
      s_nxt.cfg_sync = 1'b1;
    end
    // -------------------------------------------------------------
    // scan sequencer
    // -------------------------------------------------------------
    s_nxt.scan_cnt = (s_r.scan_cnt == 32'(analog_cycles - 1)) ? '0 : s_r.scan_cnt + 32'h1;
    s_nxt.logic_cnt = (s_r.logic_cnt == 32'(logic_cycles - 1)) ? '0 : s_r.logic_cnt + 32'h1;
    case (s_r.st)
      lead_reserve_pkg::st_idle: begin
        // a scan never starts faster than the analog period
        if (s_r.decided && s_r.scan_cnt == '0) begin
          s_nxt.st = lead_reserve_pkg::st_sample;
        end
      end
      lead_reserve_pkg::st_sample: begin
        s_nxt.blk = 8'h1;
        s_nxt.st = (s_r.mode == lead_reserve_pkg::mode_prog)
                   ? lead_reserve_pkg::st_update : lead_reserve_pkg::st_exec;
      end
      lead_reserve_pkg::st_exec: begin
        if (s_r.blk == 8'(block_count) || s_r.mode == lead_reserve_pkg::mode_prog) begin
          s_nxt.st = lead_reserve_pkg::st_update;
        end else begin
          s_nxt.blk = s_r.blk + 8'h1;
        end
      end
      lead_reserve_pkg::st_update: begin
        s_nxt.st = lead_reserve_pkg::st_sync;
      end
      lead_reserve_pkg::st_sync: begin
        s_nxt.rt_sync = s_nxt.lead;
        s_nxt.st = lead_reserve_pkg::st_idle;
      end
      default: begin
        s_nxt.st = lead_reserve_pkg::st_idle;
      end
    endcase
    // -------------------------------------------------------------
    // axi4-lite slave: one outstanding write and read
    // -------------------------------------------------------------
    s_nxt.awr = wr_go;
    s_nxt.arr = s_axi_arvalid && !s_r.rv;
    if (wr_go) begin
      s_nxt.bv = 1'b1;
      s_nxt.bresp = (waddr == lead_reserve_pkg::reg_ctrl || waddr == lead_reserve_pkg::reg_host_word
                     || waddr == lead_reserve_pkg::reg_diag)
                    ? lead_reserve_pkg::resp_okay : lead_reserve_pkg::resp_slverr;
    end else if (s_r.bv && s_axi_bready) begin
      s_nxt.bv = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rv) begin
      s_nxt.rv = 1'b1;
      s_nxt.rresp = lead_reserve_pkg::resp_okay;
      case (raddr)
        lead_reserve_pkg::reg_ctrl: s_nxt.rd = {24'h0, s_r.ctrl};
        lead_reserve_pkg::reg_host_word: s_nxt.rd = s_r.host_word;
        lead_reserve_pkg::reg_status: s_nxt.rd = {24'h0, s_r.st, s_r.mode, s_r.decided,
                                                   !s_r.lead, s_r.lead};
        lead_reserve_pkg::reg_diag: s_nxt.rd = {29'h0, s_r.diag};
        lead_reserve_pkg::reg_scan: s_nxt.rd = {24'h0, s_r.blk};
        default: begin
          s_nxt.rd = lead_reserve_pkg::reset_word;
          s_nxt.rresp = lead_reserve_pkg::resp_slverr;
        end
      endcase
    end else if (s_r.rv && s_axi_rready) begin
      s_nxt.rv = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.mode <= lead_reserve_pkg::mode_prog;
      s_r.st <= lead_reserve_pkg::st_idle;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {is_lead, is_reserve, failover_pulse, status_to_peer, poll_racks} <= '0;
      {sample_inputs, exec_block, user_block, write_outputs, net_tx_enable} <= '0;
      {sync_runtime, sync_config, cold_start, store_flash, reserve_diag} <= '0;
      mode <= lead_reserve_pkg::mode_prog;
      outputs_off <= 1'b1;
      block_num <= 8'h0;
    end else if (ce) begin
      is_lead <= s_nxt.decided && s_nxt.lead;
      is_reserve <= s_nxt.decided && !s_nxt.lead;
      failover_pulse <= s_nxt.fo;
      mode <= s_nxt.mode;
      status_to_peer <= s_nxt.decided && !(s_fault || s_rack || s_exc);
      poll_racks <= s_nxt.lead && s_nxt.st == lead_reserve_pkg::st_sample;
      sample_inputs <= s_nxt.st == lead_reserve_pkg::st_sample;
      exec_block <= s_nxt.st == lead_reserve_pkg::st_exec;
      block_num <= s_nxt.blk;
      user_block <= s_nxt.blk >= 8'(lead_reserve_pkg::first_user_block);
      // failover pulses no outputs; racks keep their last values meanwhile
      write_outputs <= s_nxt.lead && s_nxt.st == lead_reserve_pkg::st_update
                       && s_nxt.mode != lead_reserve_pkg::mode_prog;
      outputs_off <= s_nxt.mode == lead_reserve_pkg::mode_prog;
      net_tx_enable <= s_nxt.decided && s_nxt.lead;
      sync_runtime <= s_nxt.rt_sync;
      sync_config <= s_nxt.cfg_sync;
      cold_start <= s_nxt.cold;
      store_flash <= s_nxt.flash;
      reserve_diag <= s_nxt.diag[lead_reserve_pkg::diag_reserve_fault];
    end
  end
  assign s_axi_awready = s_r.awr;
  assign s_axi_wready = s_r.awr;
  assign s_axi_bvalid = s_r.bv;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arr;
  assign s_axi_rvalid = s_r.rv;
  assign s_axi_rdata = s_r.rd;
  assign s_axi_rresp = s_r.rresp;
endmodule
`default_nettype wire

/* hw/lead_reserve_pkg.sv */
// Purpose: constants for the lead/reserve arbiter of a redundant cpu pair
// Assumes: 50 MHz aclk, axi4-lite register access
// Notes: offsets are byte addresses of aligned 32-bit words
// What this block does
// - first cpu to become available takes lead, other takes reserve, no setup
// - simultaneous availability at start-up gives lead to left rack position
// - lead fault or power loss starts failover; reserve becomes the new lead
// - reserve fault or power loss only raises a diagnostic in the lead
// - after failover the new lead keeps the role; no automatic return
// - lead loss of any i/o rack or processor exception triggers failover
// - loss of host, serial slave, operator or peer links never fails over
// - manual failover from key switch, pc, modbus host or status block
// - failure detection plus failover completes within 4 analog cycles
// - modes run, run/program, program; change from key, pc, host word 0 bit 6
// - lead and reserve always share one mode; program on lead forces reserve
// - run mode executes everything and rejects on-line edits
// - run/program executes, accepts edits, stores them in ram and flash
// - program mode turns outputs off, stops blocks, accepts configuration
// - leaving program cold-starts history blocks and stores config in ram, flash
// - lead polls racks, both cpus read and execute, only lead writes outputs
// - scan period at least 500 ms analog; the 53 ms logic count runs but paces no scan
// - fixed block order; slots 1..100 system, user blocks from 101
// - inputs sampled before scan; outputs at scan end except pulse output blocks
// - lead copies run data each cycle, config on download and reserve bring-up
// - cpus exchange status through the rack scanners to judge failover
// - reserve never transmits on networks until it becomes lead
package lead_reserve_pkg;
  localparam logic [7:0] reg_ctrl = 8'h00;
  localparam logic [7:0] reg_host_word = 8'h04;
  localparam logic [7:0] reg_status = 8'h08;
  localparam logic [7:0] reg_diag = 8'h0c;
  localparam logic [7:0] reg_scan = 8'h10;
  // ctrl bits: [1:0] mode request, 2 mode write, 3 manual failover pc,
  // 4 manual failover modbus host, 5 config download, 6 edit request
  localparam int ctrl_mode_lo = 0;
  localparam int ctrl_mode_wr = 2;
  localparam int ctrl_fo_pc = 3;
  localparam int ctrl_fo_host = 4;
  localparam int ctrl_download = 5;
  localparam int ctrl_edit = 6;
  localparam int host_prog_bit = 6;
  localparam int diag_reserve_fault = 0;
  localparam int diag_edit_rejected = 1;
  localparam int diag_failover_seen = 2;
  localparam int analog_scan_ms = 500;
  localparam int logic_scan_ms = 53;
  localparam int clk_mhz = 50;
  localparam int analog_scan_cycles = analog_scan_ms * 1000 * clk_mhz;
  localparam int logic_scan_cycles = logic_scan_ms * 1000 * clk_mhz;
  localparam int failover_max_cycles = 4;
  localparam int system_blocks = 100;
  localparam int first_user_block = 101;
  localparam logic [1:0] mode_run = 2'h0;
  localparam logic [1:0] mode_runprog = 2'h1;
  localparam logic [1:0] mode_prog = 2'h2;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam logic [31:0] reset_word = 32'h0000_0000;
  typedef enum logic [2:0] {
    st_idle, st_sample, st_exec, st_update, st_sync
  } scan_state_t;
endpackage

/* hw/input_sync.sv */
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: single aclk domain
// Notes: first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
  parameter int width = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);
  logic [width-1:0] meta_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* testbench/arbiter_asserts.sv */
// Purpose: concurrent checks on the lead/reserve arbiter ports
// Assumes: one aclk domain, ce held high by the bench
// Notes: repeat counts cover the two-cycle input synchroniser lag
`timescale 1ns/1ns
`default_nettype none
module arbiter_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rack_comm_lost,
  input wire logic peer_available,
  input wire logic peer_fault,
  input wire logic is_lead,
  input wire logic is_reserve,
  input wire logic [1:0] mode,
  input wire logic exec_block,
  input wire logic [7:0] block_num,
  input wire logic user_block,
  input wire logic write_outputs,
  input wire logic outputs_off,
  input wire logic net_tx_enable,
  input wire logic poll_racks,
  input wire logic sample_inputs,
  input wire logic sync_runtime,
  input wire logic cold_start,
  input wire logic reserve_diag
);
  localparam logic [1:0] prog = lead_reserve_pkg::mode_prog;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----
  // roles
  // ----
  a_tx_lead:
    assert property (net_tx_enable == is_lead) else $error("transmit does not follow lead");
  a_one_role:
    assert property (!(is_lead && is_reserve)) else $error("lead and reserve at once");
  a_keep_reserve:
    assert property ((is_reserve && peer_available && !peer_fault)[*4] |=> is_reserve)
    else $error("reserve left its role without cause");
  a_fail_bound:
    assert property ($rose(rack_comm_lost) && is_lead && peer_available && !peer_fault
      |-> ##[1:8] !is_lead) else $error("lead kept after rack loss");
  a_diag_only:
    assert property ((is_lead && peer_fault)[*4] |-> ##[0:3] reserve_diag && is_lead)
    else $error("reserve fault not flagged or lead lost");
  // ----
  // modes and scan
  // ----
  a_prog_off:
    assert property (outputs_off == (mode == prog)) else $error("outputs off wrong");
  a_prog_stop:
    assert property ((mode == prog)[*3] |-> !exec_block) else $error("blocks run in program");
  a_cold_start:
    assert property ($past(mode) == prog && mode != prog |-> ##[0:4] cold_start)
    else $error("no cold start on leaving program");
  a_user_slot:
    assert property (user_block == (block_num >= 8'h65)) else $error("user block flag wrong");
  a_outputs_lead:
    assert property (write_outputs |-> is_lead && !outputs_off)
    else $error("outputs written by reserve or in program");
  a_poll_sample:
    assert property (poll_racks |-> is_lead && sample_inputs) else $error("bad poll");
  a_sync_lead:
    assert property (sync_runtime |-> is_lead) else $error("run data copied by reserve");
endmodule
bind lead_reserve_arbiter arbiter_asserts arbiter_asserts_i (.aclk, .aresetn,
  .rack_comm_lost, .peer_available, .peer_fault, .is_lead, .is_reserve, .mode, .exec_block,
  .block_num, .user_block, .write_outputs, .outputs_off, .net_tx_enable, .poll_racks,
  .sample_inputs, .sync_runtime, .cold_start, .reserve_diag);
`default_nettype wire

/* testbench/peer_cpu_model.sv */
// Purpose: behavioural peer cpu with status relayed by the rack scanners
// Assumes: bench sets power, claim and fault just after a clock edge
// Notes: an unpowered peer shows a changed mode, not its last one
`timescale 1ns/1ns
`default_nettype none
module peer_cpu_model (
  input wire logic powered,
  input wire logic claim,
  input wire logic broken,
  input wire logic is_reserve,
  input wire logic [1:0] mode,
  output logic peer_available,
  output logic peer_is_lead,
  output logic peer_fault,
  output logic [1:0] peer_mode
);
  // ----
  // status relay
  // ----
  assign peer_available = powered;
  assign peer_fault = powered & broken;
  // leads if it won start-up or the arbiter stepped down; a faulted peer gives up
  assign peer_is_lead = powered & ~broken & (claim | is_reserve);
  assign peer_mode = powered ? mode : ~mode;
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench for the lead/reserve arbiter
// Assumes: peer model on the far side, short scan parameters
// Notes: expectations come from the documented behaviour only
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int ana = 200;
  localparam logic [1:0] prog = lead_reserve_pkg::mode_prog;
  localparam logic [7:0] ctl = lead_reserve_pkg::reg_ctrl;
  localparam logic [7:0] hw = lead_reserve_pkg::reg_host_word;
  localparam logic [7:0] dg = lead_reserve_pkg::reg_diag;
  logic aclk, aresetn, ce, self_available, left_position, self_fault, rack_comm_lost;
  logic proc_exception, host_comm_lost, slave_comm_lost, oi_comm_lost, peer_ctrl_comm_lost;
  logic key_failover, redundancy_status_block_failover, powered, claim, broken;
  logic peer_available, peer_is_lead, peer_fault;
  logic [1:0] key_mode, peer_mode, mode, s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic is_lead, is_reserve, failover_pulse, status_to_peer, poll_racks, sample_inputs;
  logic exec_block, user_block, write_outputs, outputs_off, net_tx_enable, sync_runtime;
  logic sync_config, cold_start, store_flash, reserve_diag;
  logic [7:0] block_num;
  logic [6:0] evt;
  int errors, total_checks;
  int cnt [4];
  assign evt = {is_lead | is_reserve, is_reserve, is_lead, store_flash, write_outputs,
    failover_pulse, cold_start};
  lead_reserve_arbiter #(.analog_cycles(ana), .logic_cycles(40)) lead_reserve_arbiter_i (.*);
  peer_cpu_model peer_cpu_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // pulses counted on the falling edge, where outputs are settled
  always @(negedge aclk) begin
    for (int i = 0; i < 4; i++) cnt[i] += int'(evt[i] === 1'b1);
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wt(input int b, input string nm);
    int n;
    n = 0;
    while (evt[b] !== 1'b1 && n < 4 * ana) begin
      @(posedge aclk);
      n++;
    end
    chk(nm, 1, evt[b]);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
    @(posedge aclk);
  endtask
  task automatic rdt(input logic [7:0] a, input logic [1:0] er);
    int n;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", er, s_axi_rresp);
    @(posedge aclk);
  endtask
  // case bits: peer powered, peer claims lead, left slot, expected lead
  task automatic rst(input logic [3:0] c);
    aresetn <= 1'b0;
    self_available <= 1'b0;
    powered <= 1'b0;
    claim <= c[2];
    left_position <= c[1];
    tick(12);
    chk("reset mode", prog, mode);
    chk("reset outputs off", 1, outputs_off);
    aresetn <= 1'b1;
    self_available <= 1'b1;
    powered <= c[3];
    wt(6, "decided");
    chk("start-up lead", c[0], is_lead);
  endtask
  task automatic trig(input int s, input logic v);
    case (s)
      0: rack_comm_lost <= v;
      1: proc_exception <= v;
      2: self_fault <= v;
      3: key_failover <= v;
      4: redundancy_status_block_failover <= v;
      5: if (v) wr(ctl, 32'h8, 2'h0);
      default: if (v) wr(ctl, 32'h10, 2'h0);
    endcase
  endtask
  task automatic conclude;
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    int c;
    {aresetn, self_available, left_position, powered, claim, broken} = 6'h0;
    {self_fault, rack_comm_lost, proc_exception, key_failover} = 4'h0;
    {host_comm_lost, slave_comm_lost, oi_comm_lost, peer_ctrl_comm_lost} = 4'h0;
    redundancy_status_block_failover = 1'b0;
    ce = 1'b1;
    key_mode = prog;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hf;
    @(posedge aclk);
    rst(4'b1110);
    rst(4'b1000);
    rst(4'b0001);
    rst(4'b1011);
    rdt(lead_reserve_pkg::reg_status, 2'h0);
    chk("status", {prog, 3'h5}, rd[4:0]);
    rdt(8'h20, lead_reserve_pkg::resp_slverr);
    {host_comm_lost, slave_comm_lost, oi_comm_lost, peer_ctrl_comm_lost} <= 4'hf;
    tick(10);
    chk("lead after link loss", 1, is_lead);
    {host_comm_lost, slave_comm_lost, oi_comm_lost, peer_ctrl_comm_lost} <= 4'h0;
    c = cnt[0];
    wr(ctl, 32'h4, 2'h0);
    tick(4);
    chk("run mode", lead_reserve_pkg::mode_run, mode);
    chk("cold start", c + 1, cnt[0]);
    chk("outputs on", 0, outputs_off);
    wr(ctl, 32'h40, 2'h0);
    rdt(dg, 2'h0);
    chk("edit refused", 1, rd[1]);
    wr(dg, 32'h2, 2'h0);
    rdt(dg, 2'h0);
    chk("edit flag cleared", 0, rd[1]);
    key_mode <= lead_reserve_pkg::mode_runprog;
    tick(6);
    chk("key mode", lead_reserve_pkg::mode_runprog, mode);
    c = cnt[3];
    wr(ctl, 32'h40, 2'h0);
    tick(4);
    chk("edit stored", 1, cnt[3] > c);
    rdt(dg, 2'h0);
    chk("edit accepted", 0, rd[1]);
    wr(hw, 32'h40, 2'h0);
    tick(4);
    chk("host program", prog, mode);
    c = cnt[2];
    tick(2 * ana);
    chk("no writes in program", c, cnt[2]);
    c = cnt[0];
    wr(hw, 32'h0, 2'h0);
    tick(4);
    chk("host run", lead_reserve_pkg::mode_run, mode);
    chk("cold start again", c + 1, cnt[0]);
    c = cnt[2];
    tick(2 * ana);
    chk("outputs written", 1, cnt[2] > c);
    for (int s = 0; s < 7; s++) begin
      c = cnt[1];
      trig(s, 1'b1);
      wt(5, "failover");
      chk("outputs held in handover", 0, write_outputs);
      trig(s, 1'b0);
      tick(10);
      chk("no return", 1, is_reserve);
      broken <= 1'b1;
      wt(4, "takeover");
      chk("failover pulses", c + 2, cnt[1]);
      tick(6);
      broken <= 1'b0;
      tick(6);
    end
    chk("reserve diag", 1, reserve_diag);
    chk("healthy status", 1, status_to_peer);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
